// file: inc/ppmc_pkg.sv
package ppmc_pkg;

  // ==========================================================================
  // port set and geometry
  // ==========================================================================
  // port order used everywhere: 0 = P2, 1 = P3, 2 = P4, 3 = P6, 4 = P7, 5 = P8
  localparam int NUM_PORTS = 6;
  localparam int PORT_BITS = 16;
  localparam int NIB_PER_PORT = 4;
  localparam int NIB_BITS = 4;
  localparam int PIN_TOTAL = NUM_PORTS * PORT_BITS;
  localparam int NIB_TOTAL = NUM_PORTS * NIB_PER_PORT;

  // implemented pins per port; 8-bit ports keep bits 15..8 at zero
  localparam logic [15:0] PORT_MASK [NUM_PORTS] = '{
    16'hFFFF, 16'hFFFF, 16'h00FF, 16'h00FF, 16'h00FF, 16'h00FF
  };

  // ==========================================================================
  // register map (byte addresses, one aligned 32-bit word each)
  // ==========================================================================
  localparam int ADDR_W = 12;
  localparam logic [11:0] THR_OFS = 12'h000;
  localparam logic [11:0] OC_BASE = 12'h004;
  // open-drain selects live only in the extended area
  localparam logic [11:0] OD_BASE = 12'h100;
  localparam int EXT_AREA_BIT = 8;

  // ==========================================================================
  // threshold select register layout
  // ==========================================================================
  localparam int THR_W = 7;
  localparam logic [6:0] THR_RESET = 7'h00;
  // bit position of the low / high byte select per port, -1 = none
  localparam int THR_LO_POS [NUM_PORTS] = '{0, 2, 4, -1, 5, 6};
  localparam int THR_HI_POS [NUM_PORTS] = '{1, 3, -1, -1, -1, -1};

  // ==========================================================================
  // reset values and nibble field layout
  // ==========================================================================
  localparam logic [15:0] OD_RESET = 16'h0000;
  localparam logic [15:0] OC_RESET = 16'h0000;
  localparam int EDGE_LSB = 0;
  localparam int DRV_LSB = 2;

  typedef enum logic [1:0] {
    PPMC_EDGE_FAST = 2'b00,
    PPMC_EDGE_SLOW = 2'b01,
    PPMC_EDGE_RSV2 = 2'b10,
    PPMC_EDGE_RSV3 = 2'b11
  } ppmc_edge_e;

  typedef enum logic [1:0] {
    PPMC_DRV_HIGH = 2'b00,
    PPMC_DRV_DYN = 2'b01,
    PPMC_DRV_LOW = 2'b10,
    PPMC_DRV_RSV = 2'b11
  } ppmc_drive_e;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 10;
  localparam int STATE_TIME_NS = 50;
  // longest time: round down, never below one cycle
  localparam int STATE_CYCLES = (STATE_TIME_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                (STATE_TIME_NS / CLK_PERIOD_NS);

endpackage

// file: logic/ppmc_nibble_decode.sv
// ============================================================================
// per-nibble pad setting decode
// ============================================================================
module ppmc_nibble_decode (
  input wire logic [3:0] field_in,
  output logic slow_edge_out,
  output ppmc_pkg::ppmc_drive_e drive_out
);

  logic [1:0] edge_code;
  logic [1:0] drv_code;

  assign edge_code = field_in[ppmc_pkg::EDGE_LSB +: 2];
  assign drv_code = field_in[ppmc_pkg::DRV_LSB +: 2];

  // reserved codes fall back to the reset setting, fast edge
  always_comb begin
    case (edge_code)
      ppmc_pkg::PPMC_EDGE_SLOW: slow_edge_out = 1'b1;
      default: slow_edge_out = 1'b0;
    endcase
  end

  // reserved driver code falls back to full strength
  always_comb begin
    case (drv_code)
      ppmc_pkg::PPMC_DRV_DYN: drive_out = ppmc_pkg::PPMC_DRV_DYN;
      ppmc_pkg::PPMC_DRV_LOW: drive_out = ppmc_pkg::PPMC_DRV_LOW;
      default: drive_out = ppmc_pkg::PPMC_DRV_HIGH;
    endcase
  end

endmodule

// file: logic/ppmc_top.sv
//
// Behaviour
// - open-drain bit clear gives push/pull, set gives open-drain; resets clear.
// - open-drain keeps high side off; latch one floats pin, zero drives low.
// - open-drain exists on P2,P3,P4,P6,P7,P8, one bit per pin.
// - open-drain selects are decoded only in the extended register area.
// - threshold select per port byte except P6; P4,P7,P8 one bit, P2,P3 two bits.
// - low-byte bit zero gives TTL levels to pins 7..0, one hysteresis.
// - high-byte bit zero gives TTL levels to pins 15..8, one hysteresis.
// - direction and output mode work the same whatever threshold is chosen.
// - each nibble has a 2-bit edge field and a 2-bit driver field.
// - edge 00 fast, 01 slow about 60 ns, 10 and 11 reserved.
// - driver field picks high, dynamic or low current, or reserved.
// - reading an 8-bit port output control register gives zero in 15..8.
// - driver code 00 high, 01 dynamic, 10 low, 11 reserved.
// - direction one enables output buffer with latch value; zero is input.
// - every pin level is sampled into the input latch once per state time.
module ppmc_top #(
  parameter int STATE_CYC = ppmc_pkg::STATE_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [95:0] port_latch_in,
  input wire logic [95:0] pin_direction_bit_in,
  input wire logic [95:0] pad_in,
  output logic [95:0] pad_data_out,
  output logic [95:0] pad_drive_n_out,
  output logic [95:0] hyst_sel_out,
  output logic [95:0] input_latch_out,
  output logic [23:0] slow_edge_out,
  output logic [47:0] drive_mode_out
);

  // ==========================================================================
  // storage
  // ==========================================================================
  logic [15:0] open_drain_select_reg [ppmc_pkg::NUM_PORTS];
  logic [15:0] output_drive_ctrl [ppmc_pkg::NUM_PORTS];
  logic [ppmc_pkg::THR_W-1:0] input_threshold_select;
  logic [95:0] od_flat;
  logic [95:0] next_pad_data;
  logic [95:0] next_drive_n;
  logic [95:0] next_hyst;
  logic [23:0] next_slow;
  logic [47:0] next_drive_mode;

  // ==========================================================================
  // apb decode
  // ==========================================================================
  logic setup_phase;
  logic access_done;
  logic wr_commit;
  logic hit_thr;
  logic hit_oc;
  logic hit_od;
  logic [2:0] hit_idx;
  logic [15:0] rd_val;
  logic [15:0] lane_mask;

  assign setup_phase = psel_in & ~penable_in;
  assign access_done = psel_in & penable_in & pready_out;
  assign wr_commit = access_done & pwrite_in;
  assign lane_mask = {{8{pstrb_in[1]}}, {8{pstrb_in[0]}}};

  // address match; open-drain words only answer in the extended area
  always_comb begin
    hit_thr = (paddr_in == ppmc_pkg::THR_OFS);
    hit_oc = 1'b0;
    hit_od = 1'b0;
    hit_idx = 3'h0;
    rd_val = 16'h0000;
    for (int i = 0; i < ppmc_pkg::NUM_PORTS; i++) begin
      if (paddr_in == ppmc_pkg::OC_BASE + 12'(4 * i)) begin
        hit_oc = 1'b1;
        hit_idx = 3'(i);
      end
      if (paddr_in == ppmc_pkg::OD_BASE + 12'(4 * i)) begin
        hit_od = 1'b1;
        hit_idx = 3'(i);
      end
    end
    if (hit_thr) begin
      rd_val = {9'h000, input_threshold_select};
    end else if (hit_oc) begin
      rd_val = output_drive_ctrl[hit_idx];
    end else if (hit_od) begin
      rd_val = open_drain_select_reg[hit_idx];
    end
  end

  // answer one cycle after setup: zero wait state, unmapped gives slverr
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pready_out <= 1'b0;
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out <= setup_phase;
      prdata_out <= (setup_phase && !pwrite_in) ? {16'h0000, rd_val} : 32'h0000_0000;
      pslverr_out <= setup_phase & ~(hit_thr | hit_oc | hit_od);
    end
  end

  // ==========================================================================
  // control registers
  // ==========================================================================
  // threshold select, only the defined byte bits exist
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      input_threshold_select <= ppmc_pkg::THR_RESET;
    end else if (wr_commit && hit_thr && pstrb_in[0]) begin
      input_threshold_select <= pwdata_in[ppmc_pkg::THR_W-1:0];
    end
  end

  // per-port words; missing pins and nibbles of 8-bit ports never store
  for (genvar p = 0; p < ppmc_pkg::NUM_PORTS; p++) begin : g_port_regs
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        open_drain_select_reg[p] <= ppmc_pkg::OD_RESET;
      end else if (wr_commit && hit_od && hit_idx == 3'(p)) begin
        open_drain_select_reg[p] <= (open_drain_select_reg[p] & ~lane_mask) |
          (pwdata_in[15:0] & lane_mask & ppmc_pkg::PORT_MASK[p]);
      end
    end

    // reserved codes are stored as written
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        output_drive_ctrl[p] <= ppmc_pkg::OC_RESET;
      end else if (wr_commit && hit_oc && hit_idx == 3'(p)) begin
        output_drive_ctrl[p] <= (output_drive_ctrl[p] & ~lane_mask) |
          (pwdata_in[15:0] & lane_mask & ppmc_pkg::PORT_MASK[p]);
      end
    end
  end

  // ==========================================================================
  // pad driver and threshold steering
  // ==========================================================================
  for (genvar p = 0; p < ppmc_pkg::NUM_PORTS; p++) begin : g_port_pads
    for (genvar b = 0; b < ppmc_pkg::PORT_BITS; b++) begin : g_pin
      localparam int PIN = p * ppmc_pkg::PORT_BITS + b;
      localparam int TPOS = (b < 8) ? ppmc_pkg::THR_LO_POS[p] : ppmc_pkg::THR_HI_POS[p];
      logic od;
      logic lat;
      logic dir;
      assign od = open_drain_select_reg[p][b];
      assign lat = port_latch_in[PIN];
      assign dir = pin_direction_bit_in[PIN] & ppmc_pkg::PORT_MASK[p][b];
      assign od_flat[PIN] = od;
      // open-drain never drives high; latch one releases the pin
      assign next_pad_data[PIN] = od ? 1'b0 : lat;
      // threshold plays no part in the drive decision
      assign next_drive_n[PIN] = ~(dir & (~od | ~lat));
      if (TPOS >= 0) begin : g_thr
        assign next_hyst[PIN] = input_threshold_select[TPOS];
      end else begin : g_no_thr
        assign next_hyst[PIN] = 1'b0;
      end
    end

    // four nibbles per port, each 2-bit edge and 2-bit driver field
    for (genvar n = 0; n < ppmc_pkg::NIB_PER_PORT; n++) begin : g_nib
      localparam int NI = p * ppmc_pkg::NIB_PER_PORT + n;
      ppmc_pkg::ppmc_drive_e drv;
      ppmc_nibble_decode u_dec (
        .field_in(output_drive_ctrl[p][n * ppmc_pkg::NIB_BITS +: ppmc_pkg::NIB_BITS]),
        .slow_edge_out(next_slow[NI]),
        .drive_out(drv)
      );
      assign next_drive_mode[2 * NI +: 2] = drv;
    end
  end

  // all pad controls leave from flops; one cycle after a register write
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pad_data_out <= 96'h0;
      pad_drive_n_out <= {96{1'b1}};
      hyst_sel_out <= 96'h0;
      slow_edge_out <= 24'h0;
      drive_mode_out <= 48'h0;
    end else begin
      pad_data_out <= next_pad_data;
      pad_drive_n_out <= next_drive_n;
      hyst_sel_out <= next_hyst;
      slow_edge_out <= next_slow;
      drive_mode_out <= next_drive_mode;
    end
  end

  // ==========================================================================
  // input sampling
  // ==========================================================================
  logic [95:0] pad_meta;
  logic [95:0] pad_sync;
  logic [15:0] state_cnt;
  logic state_tick;
  logic [95:0] impl_mask;

  for (genvar p = 0; p < ppmc_pkg::NUM_PORTS; p++) begin : g_mask
    assign impl_mask[p * 16 +: 16] = ppmc_pkg::PORT_MASK[p];
  end

  // pins are asynchronous: two flops before anything looks at them
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      pad_meta <= 96'h0;
      pad_sync <= 96'h0;
    end else begin
      pad_meta <= pad_in;
      pad_sync <= pad_meta;
    end
  end

  // state-time divider, one-cycle enable
  assign state_tick = (state_cnt == 16'(STATE_CYC - 1));

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_cnt <= 16'h0000;
    end else if (state_tick) begin
      state_cnt <= 16'h0000;
    end else begin
      state_cnt <= state_cnt + 16'h0001;
    end
  end

  // sampled regardless of direction, so an output reads back its own pin
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      input_latch_out <= 96'h0;
    end else if (state_tick) begin
      input_latch_out <= pad_sync & impl_mask;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // open-drain checks
  od_reset_clear_a: assert property ($fell(rst_in) |-> od_flat == 96'h0)
    else $error("open-drain selects not clear after reset");
  od_no_high_a: assert property (
    ((~pad_drive_n_out & pad_data_out & $past(od_flat)) == 96'h0))
    else $error("open-drain pin driven high");
  od_float_a: assert property (
    $past(od_flat[0] & port_latch_in[0] & pin_direction_bit_in[0]) |-> pad_drive_n_out[0])
    else $error("open-drain pin with latch one not released");
  od_narrow_a: assert property (
    (od_flat[47:40] | od_flat[63:56] | od_flat[79:72] | od_flat[95:88]) == 8'h00)
    else $error("open-drain bit exists on missing pin");
  od_ext_only_a: assert property (
    (wr_commit && !paddr_in[ppmc_pkg::EXT_AREA_BIT]) |=> $stable(od_flat))
    else $error("open-drain select written from standard area");

  // threshold checks; the select must never reach the drive path
  thr_low_a: assert property (hyst_sel_out[7:0] == {8{$past(input_threshold_select[0])}})
    else $error("low byte threshold mismatch");
  thr_high_a: assert property (
    hyst_sel_out[31:24] == {8{$past(input_threshold_select[3])}})
    else $error("high byte threshold mismatch");
  thr_byte_a: assert property (
    hyst_sel_out[79:64] == {8'h00, {8{$past(input_threshold_select[5])}}})
    else $error("8-bit port threshold select mismatch");
  p6_ttl_a: assert property (hyst_sel_out[63:48] == 16'h0000)
    else $error("port without threshold select left standard levels");
  thr_no_drive_a: assert property (
    ($changed(input_threshold_select) && $stable(pin_direction_bit_in) &&
     $stable(port_latch_in) && $stable(od_flat)) |=> $stable(pad_drive_n_out))
    else $error("threshold change altered output drive");

  // direction checks; a reset cycle in the history would look like a dead driver
  dir_drive_a: assert property (
    $past(pin_direction_bit_in[2] & ~od_flat[2] & ~rst_in) |->
      (!pad_drive_n_out[2] && pad_data_out[2] == $past(port_latch_in[2])))
    else $error("output buffer not enabled by direction");
  dir_input_a: assert property ($past(!pin_direction_bit_in[5]) |-> pad_drive_n_out[5])
    else $error("input pin driven");

  // register storage and nibble decode checks
  oc_hi_zero_a: assert property (
    (setup_phase && !pwrite_in && paddr_in == ppmc_pkg::OC_BASE + 12'h010)
      |=> prdata_out[15:8] == 8'h00)
    else $error("8-bit output control high byte not zero");
  oc_narrow_a: assert property (
    (output_drive_ctrl[2][15:8] | output_drive_ctrl[3][15:8] |
     output_drive_ctrl[4][15:8] | output_drive_ctrl[5][15:8]) == 8'h00)
    else $error("8-bit port output control holds high byte");
  oc_reset_a: assert property (
    $fell(rst_in) |-> (output_drive_ctrl[0] == ppmc_pkg::OC_RESET &&
      output_drive_ctrl[1] == ppmc_pkg::OC_RESET))
    else $error("16-bit output control not clear after reset");
  edge_slow_a: assert property (
    $past(output_drive_ctrl[0][1:0]) == 2'b01 |-> slow_edge_out[0])
    else $error("slow edge not applied");
  drv_rsvd_a: assert property (
    $past(output_drive_ctrl[0][15:14]) == 2'b11 |->
      (drive_mode_out[7:6] == 2'b00 &&
       !slow_edge_out[3] == ($past(output_drive_ctrl[0][13:12]) != 2'b01)))
    else $error("reserved code did not fall back");
  drv_map_a: assert property (
    $past(output_drive_ctrl[0][11:10]) == 2'b10 |-> drive_mode_out[5:4] == 2'b10)
    else $error("low current code not applied");

  // state-time sampling and bus timing
  sample_rate_a: assert property ($changed(input_latch_out) |-> $past(state_tick))
    else $error("input latch changed off state time");
  sample_val_a: assert property (
    $past(state_tick) |-> input_latch_out == ($past(pad_sync) & impl_mask))
    else $error("input latch does not hold sampled pins");
  apb_answer_a: assert property (setup_phase |=> pready_out ##1 !pready_out)
    else $error("apb answer not one cycle");
  rd_upper_a: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
    else $error("read data upper half not zero");
  slverr_only_a: assert property (pslverr_out |-> pready_out)
    else $error("error flag outside access phase");
  unmapped_err_a: assert property (
    (setup_phase && !(hit_thr || hit_oc || hit_od)) |=> (pslverr_out && prdata_out == 32'h0))
    else $error("unmapped access not refused");

  // main scenarios worth seeing at least once
  od_write_c: cover property (wr_commit && hit_od);
  rsvd_write_c: cover property (wr_commit && hit_oc && pwdata_in[3:2] == 2'b11);
  od_float_c: cover property (!pad_drive_n_out[0] ##1 pad_drive_n_out[0] && od_flat[0]);
  unmapped_c: cover property (access_done && pslverr_out);
  thr_write_c: cover property (wr_commit && hit_thr);

endmodule

// file: verif/ppmc_pad_model.sv
// ============================================================================
// pad drivers and input buffers seen from the pins
// ============================================================================
module ppmc_pad_model (
  input wire logic [95:0] pad_data_in,
  input wire logic [95:0] pad_drive_n_in,
  input wire logic [95:0] ext_en_in,
  input wire logic [95:0] ext_val_in,
  output logic [95:0] pad_level_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // own driver wins, then an outside driver, else the board pull-up
  // a released open-drain line must float high, never hold its last value
  always_comb begin
    for (int i = 0; i < 96; i++) begin
      if (!pad_drive_n_in[i]) pad_level_out[i] = pad_data_in[i];
      else if (ext_en_in[i]) pad_level_out[i] = ext_val_in[i];
      else pad_level_out[i] = 1'b1;
    end
  end
endmodule

// file: verif/tb_top.sv
// ============================================================================
// pad mode control bench
// ============================================================================
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SC = 5;
  logic clk;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [95:0] latch = '0;
  logic [95:0] dir = '0;
  logic [95:0] ext_en = '0;
  logic [95:0] ext_val = '0;
  logic [95:0] pad_lvl, pad_data, pad_drv_n, hyst, in_latch;
  logic [23:0] slow;
  logic [47:0] drv;
  int miscompares = 0;
  int check_count = 0;

  // ==========================================================================
  // design and pins
  // ==========================================================================
  ppmc_top #(.STATE_CYC(SC)) DUT (
    .ref_clk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(pstrb),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .port_latch_in(latch), .pin_direction_bit_in(dir), .pad_in(pad_lvl),
    .pad_data_out(pad_data), .pad_drive_n_out(pad_drv_n), .hyst_sel_out(hyst),
    .input_latch_out(in_latch), .slow_edge_out(slow), .drive_mode_out(drv)
  );

  ppmc_pad_model pads (
    .pad_data_in(pad_data), .pad_drive_n_in(pad_drv_n), .ext_en_in(ext_en),
    .ext_val_in(ext_val), .pad_level_out(pad_lvl)
  );

  // ==========================================================================
  // shared tasks
  // ==========================================================================
  task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // one apb transfer; waits for pready however long, only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk({64'h0, q}, {64'h0, exp}, "read data");
    chk(e, exp_err, "read error flag");
  endtask

  // let the write edge and the output register update land
  task automatic settle();
    repeat (2) @(posedge clk);
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_reset();
    chk(pad_drv_n, ~96'h0, "drivers off after reset");
    chk(hyst, '0, "ttl levels after reset");
    chk({slow, drv}, '0, "fast high after reset");
    rd(12'h000, 32'h0, 1'b0);
    rd(12'h008, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b0);
    rd(12'h10C, 32'h0, 1'b0);
  endtask

  task automatic t_open_drain();
    dir <= 96'hF;
    latch <= 96'h5;
    settle();
    chk(pad_drv_n, ~96'hF, "push pull enables");
    chk(pad_data, 96'h5, "push pull data");
    wr(12'h100, 32'h0000_0003);
    settle();
    chk(pad_drv_n, ~96'hE, "open drain one floats");
    chk(pad_data, 96'h4, "open drain high side off");
    wr(12'h004, 32'h0000_0000);
    rd(12'h100, 32'h0000_0003, 1'b0);
    wr(12'h114, 32'h0000_FFFF);
    rd(12'h114, 32'h0000_00FF, 1'b0);
    wr(12'h114, 32'h0000_0000);
  endtask

  task automatic t_threshold();
    wr(12'h000, 32'h0000_0001);
    settle();
    chk(hyst, 96'h00FF, "low byte only");
    wr(12'h000, 32'h0000_007F);
    settle();
    chk(hyst, {16'h00FF, 16'h00FF, 16'h0000, 16'h00FF, 32'hFFFF_FFFF}, "all bytes");
    rd(12'h000, 32'h0000_007F, 1'b0);
    chk(pad_drv_n, ~96'hE, "mode kept with hysteresis");
    chk(pad_data, 96'h4, "data kept with hysteresis");
    wr(12'h000, 32'h0000_0000);
  endtask

  // every edge and driver code, reserved ones included
  task automatic t_nibble();
    wr(12'h004, 32'h0000_E841);
    wr(12'h008, 32'h0000_7BCD);
    wr(12'h014, 32'h0000_FFFF);
    settle();
    chk(slow, 24'h000011, "edge decode");
    chk(drv, 48'h0000_0000_6024, "driver decode");
    rd(12'h004, 32'h0000_E841, 1'b0);
    rd(12'h008, 32'h0000_7BCD, 1'b0);
    rd(12'h014, 32'h0000_00FF, 1'b0);
  endtask

  // pins sampled whatever their direction
  task automatic t_input();
    ext_en[67] <= 1'b1;
    ext_val[67] <= 1'b0;
    repeat (SC + 6) @(posedge clk);
    chk({in_latch[67], in_latch[1], in_latch[0]}, 3'b001, "input latch low");
    ext_val[67] <= 1'b1;
    repeat (SC + 6) @(posedge clk);
    chk({in_latch[67], in_latch[1], in_latch[0]}, 3'b101, "input latch high");
  endtask

  // a seventh open-drain slot does not exist
  task automatic t_unmapped();
    wr(12'h118, 32'h0000_FFFF);
    rd(12'h118, 32'h0, 1'b1);
    rd(12'h01C, 32'h0, 1'b1);
  endtask

  // mid-run reset must clear every stored setting, not only the first one
  task automatic t_rereset();
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle();
    chk({slow, drv}, '0, "edge and driver after second reset");
    rd(12'h004, 32'h0, 1'b0);
    rd(12'h100, 32'h0, 1'b0);
  endtask

  task automatic conclude();
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ==========================================================================
  // clock, main sequence, watchdog
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_open_drain();
    t_threshold();
    t_nibble();
    t_rereset();
    t_input();
    t_unmapped();
    conclude();
  end

  // whole run is about 120 cycles; a hang ends here
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    conclude();
  end
endmodule
